// ---- insn_exec.sv ----
// Executor for rotate-through-carry, halt and literal-minus-accumulator instructions.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module insn_exec
  import exec_pkg::*;
#(
  parameter int WDOG_W = 8,
  parameter int PRE_W  = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   sleep_mode,
  output logic      [WDOG_W-1:0] watchdog_counter
);

  // Subtraction a - b as a + ~b + 1, carry out is the no-borrow flag.
  function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
    sub9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction : sub9

  logic [7:0]       file_mem [0:127];
  logic [13:0]      op;
  logic [7:0]       acc;
  flags_s           flags;
  phase_e           phase;
  logic [7:0]       operand;
  logic [7:0]       result;
  logic             res_carry;
  logic             res_half;
  logic [6:0]       faddr;
  logic [PRE_W-1:0] prescaler;
  logic             dropped;

  // APB access decode.
  wire access   = psel & penable & ~pready;
  wire wr_acc   = access & pwrite;
  wire hit_ins  = paddr == OFF_INSTR;
  wire hit_acc  = paddr == OFF_ACC;
  wire hit_stat = paddr == OFF_STAT;
  wire hit_fa   = paddr == OFF_FADDR;
  wire hit_fd   = paddr == OFF_FDATA;
  wire hit_wd   = paddr == OFF_WDOG;
  wire hit_wake = paddr == OFF_WAKE;
  wire mapped   = hit_ins | hit_acc | hit_stat | hit_fa | hit_fd | hit_wd | hit_wake;
  wire launch   = wr_acc & hit_ins & (phase == PH_IDLE) & ~sleep_mode;
  wire refuse   = wr_acc & hit_ins & ~launch;

  // Instruction class decode of the latched word.
  wire is_rlc  = op[13:8] == OPC_RLC;
  wire is_rrc  = op[13:8] == OPC_RRC;
  wire is_rot  = is_rlc | is_rrc;
  wire is_halt = op == OPC_HALT;
  wire is_lsub = op[13:9] == OPC_LSUB;
  wire to_file = op[DEST_BIT];
  wire [6:0] op_addr = op[ADDR_MSB:0];

  // Subtraction arithmetic on literal and accumulator.
  wire [8:0] diff   = sub9(op[7:0], acc);
  wire [4:0] diff_lo = {1'b0, op[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  // Read data selection.
  wire [31:0] rd_sel =
      hit_ins  ? {18'h00000, op} :
      hit_acc  ? {24'h000000, acc} :
      hit_stat ? {24'h000000, dropped, phase != PH_IDLE, sleep_mode, flags} :
      hit_fa   ? {25'h0000000, faddr} :
      hit_fd   ? {24'h000000, file_mem[faddr]} :
      hit_wd   ? {{(32 - WDOG_W){1'b0}}, watchdog_counter} : 32'h00000000;

  // APB answer: one wait state, then ready with data or error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access & ~mapped;
      prdata  <= (access & ~pwrite) ? rd_sel : 32'h00000000;
    end
  end

  // Phase sequencer for one instruction cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_IDLE;
      op    <= 14'h0000;
    end else begin
      case (phase)
        PH_IDLE: begin
          if (launch) begin
            op    <= pwdata[13:0];
            phase <= PH_Q1;
          end
        end
        PH_Q1:   phase <= PH_Q2;
        PH_Q2:   phase <= PH_Q3;
        PH_Q3:   phase <= PH_Q4;
        PH_Q4:   phase <= PH_IDLE;
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // Q2 reads the file register, Q3 computes the result.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand   <= 8'h00;
      result    <= 8'h00;
      res_carry <= 1'b0;
      res_half  <= 1'b0;
    end else begin
      if (phase == PH_Q2 && is_rot) begin
        operand <= file_mem[op_addr];
      end
      if (phase == PH_Q3 && is_rlc) begin
        result    <= {operand[6:0], flags.carry};
        res_carry <= operand[7];
      end else if (phase == PH_Q3 && is_rrc) begin
        result    <= {flags.carry, operand[7:1]};
        res_carry <= operand[0];
      end else if (phase == PH_Q3 && is_lsub) begin
        result    <= diff[7:0];
        res_carry <= diff[8];
        res_half  <= diff_lo[4];
      end
    end
  end

  // Q4 writes accumulator, flags and low-power state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc        <= ACC_RST;
      flags      <= FLAGS_RST;
      sleep_mode <= 1'b0;
      faddr      <= 7'h00;
      dropped    <= 1'b0;
    end else begin
      if (wr_acc && hit_acc) begin
        acc <= pwdata[7:0];
      end
      if (wr_acc && hit_stat) begin
        flags   <= pwdata[4:0];
        dropped <= 1'b0;
      end
      if (wr_acc && hit_fa) begin
        faddr <= pwdata[6:0];
      end
      if (wr_acc && hit_wake) begin
        sleep_mode <= 1'b0;
      end
      if (refuse) begin
        dropped <= 1'b1;
      end
      if (phase == PH_Q4 && is_rot) begin
        flags.carry <= res_carry;
        if (!to_file) begin
          acc <= result;
        end
      end
      if (phase == PH_Q4 && is_lsub) begin
        acc                   <= result;
        flags.carry           <= res_carry;
        flags.half_carry_flag <= res_half;
        flags.zero            <= result == 8'h00;
      end
      if (phase == PH_Q4 && is_halt) begin
        flags.power_down_flag      <= 1'b0;
        flags.watchdog_expiry_flag <= 1'b1;
        sleep_mode                 <= 1'b1;
      end
    end
  end

  // File registers; the rotate write in Q4 wins over a bus write.
  always_ff @(posedge pclk) begin
    if (phase == PH_Q4 && is_rot && to_file) begin
      file_mem[op_addr] <= result;
    end else if (wr_acc && hit_fd) begin
      file_mem[faddr] <= pwdata[7:0];
    end
  end

  // Watchdog counter and prescaler, cleared by halt in Q4.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler        <= '0;
      watchdog_counter <= '0;
    end else if (phase == PH_Q4 && is_halt) begin
      prescaler        <= '0;
      watchdog_counter <= '0;
    end else begin
      prescaler <= prescaler + 1'b1;
      if (&prescaler) begin
        watchdog_counter <= watchdog_counter + 1'b1;
      end
    end
  end

  // Checks of the instruction behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_rlc_value: assert property (
    phase == PH_Q3 && is_rlc |=> result == {$past(operand[6:0]), $past(flags.carry)})
    else $error("left rotate result wrong");

  a_rrc_value: assert property (
    phase == PH_Q3 && is_rrc |=> result == {$past(flags.carry), $past(operand[7:1])})
    else $error("right rotate result wrong");

  a_dest_acc: assert property (
    phase == PH_Q4 && is_rot && !to_file |=> acc == $past(result))
    else $error("rotate to accumulator missed");

  a_dest_file: assert property (
    phase == PH_Q4 && is_rot && to_file && !(wr_acc && hit_acc) |=> acc == $past(acc))
    else $error("rotate to file touched accumulator");

  a_phase_walk: assert property (
    launch |=> phase == PH_Q1 ##1 phase == PH_Q2 ##1 phase == PH_Q3 ##1 phase == PH_Q4
    ##1 phase == PH_IDLE)
    else $error("phase sequence broken");

  a_rot_carry: assert property (
    phase == PH_Q3 && is_rlc |=> res_carry == $past(operand[7]))
    else $error("left rotate carry wrong");

  a_halt_flags: assert property (
    phase == PH_Q4 && is_halt |=> !flags.power_down_flag && flags.watchdog_expiry_flag)
    else $error("halt flags wrong");

  a_halt_wdog: assert property (
    phase == PH_Q4 && is_halt |=> watchdog_counter == '0 && prescaler == '0)
    else $error("halt did not clear watchdog");

  a_halt_sleep: assert property (
    phase == PH_Q1 && is_halt |=> !sleep_mode [*3] ##1 sleep_mode)
    else $error("halt sleep timing wrong");

  a_sub_value: assert property (
    phase == PH_Q4 && is_lsub |=> acc == 8'(($past(op[7:0]) - $past(acc, 2))))
    else $error("literal minus accumulator wrong");

  a_sub_zero: assert property (
    phase == PH_Q4 && is_lsub |=> flags.zero == (acc == 8'h00)
    && flags.carry == ($past(op[7:0]) >= $past(acc, 2)))
    else $error("subtract zero or carry wrong");

  a_sub_half: assert property (
    phase == PH_Q4 && is_lsub |=> flags.half_carry_flag == ($past(op[3:0]) >= $past(acc[3:0], 2)))
    else $error("subtract half carry wrong");

endmodule : insn_exec

// ---- exec_pkg.sv ----
// Package with offsets, reset values, opcodes, states and flag layout of the executor.
package exec_pkg;
  // Byte offsets of the APB registers.
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC   = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_FADDR = 8'h0C;
  localparam logic [7:0] OFF_FDATA = 8'h10;
  localparam logic [7:0] OFF_WDOG  = 8'h14;
  localparam logic [7:0] OFF_WAKE  = 8'h18;
  // Opcode patterns.
  localparam logic [5:0]  OPC_RLC  = 6'h0D;
  localparam logic [5:0]  OPC_RRC  = 6'h0C;
  localparam logic [13:0] OPC_HALT = 14'h0063;
  localparam logic [4:0]  OPC_LSUB = 5'h1E;
  // Field positions inside an instruction word.
  localparam int DEST_BIT = 7;
  localparam int ADDR_MSB = 6;
  // Status field positions (flags occupy bits 4..0).
  localparam int STAT_SLEEP = 5;
  localparam int STAT_BUSY  = 6;
  localparam int STAT_DROP  = 7;
  // Flag values after reset: both active-low status flags high.
  localparam logic [4:0] FLAGS_RST = 5'h18;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] WDOG_RST  = 8'h00;
  // Instruction cycle phases.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } phase_e;
  // Status flags as one word; order gives bit positions 4..0.
  typedef struct packed {
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } flags_s;
endpackage : exec_pkg

// ---- tb.sv ----
// Self-checking bench for the rotate, halt and literal-subtract executor.
`timescale 1ns/1ps
module tb;
  import exec_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_mode;
  logic [7:0]  watchdog_counter;
  logic [32:0] exp_q[$];
  string       name_q[$];
  int          num_errors;
  int          n_checks;
  int          cycles;
  logic [7:0]  v;
  logic [7:0]  a;
  logic [7:0]  k;
  logic [7:0]  r;
  logic [6:0]  f;
  logic [1:0]  lo;
  logic        c;
  logic        d;
  logic        op;

  insn_exec #(.PRE_W(2)) insn_exec_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .watchdog_counter(watchdog_counter));

  // Clock of 5 ns period.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Compares one value and counts the comparison.
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask : check

  // Prints the verdict and stops the run.
  task automatic test_done;
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // One APB transfer, entered right after a rising edge, held until pready.
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  // Reads a register after noting its expected value and slave error.
  task automatic rd(input string nm, input logic [7:0] ad, input logic [32:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    xfer(1'b0, ad, 32'h0);
  endtask : rd

  // Launches an instruction and waits a fixed four edges after the transfer.
  task automatic exec(input logic [13:0] insn);
    xfer(1'b1, OFF_INSTR, {18'h0, insn});
    repeat (4) @(posedge pclk);
  endtask : exec

  // Watches answered reads and compares them with the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check(name_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Cuts a hang short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(26175));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("reset status", OFF_STAT, {25'h0, 8'h18});
    rd("unmapped", 8'h1C, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      a = 8'($urandom);
      f = (i == 0) ? 7'h7F : 7'($urandom);
      {c, lo} = 3'($urandom);
      d = i[0];
      op = i[1];
      r = op ? {v[6:0], c} : {c, v[7:1]};
      xfer(1'b1, OFF_FADDR, {25'h0, f});
      xfer(1'b1, OFF_FDATA, {24'h0, v});
      xfer(1'b1, OFF_ACC, {24'h0, a});
      xfer(1'b1, OFF_STAT, {27'h0, 2'b11, lo, c});
      exec({op ? OPC_RLC : OPC_RRC, d, f});
      rd("rotate acc", OFF_ACC, {25'h0, d ? a : r});
      rd("rotate file", OFF_FDATA, {25'h0, d ? r : v});
      rd("rotate flags", OFF_STAT, {28'h0, 2'b11, lo, op ? v[7] : v[0]});
    end
    for (int i = 0; i < 8; i++) begin
      k = (i < 2) ? 8'h02 : 8'($urandom);
      a = (i < 2) ? 8'h02 + 8'(i) : 8'($urandom);
      {c, lo} = 3'($urandom);
      d = i[0];
      r = k - a;
      xfer(1'b1, OFF_ACC, {24'h0, a});
      xfer(1'b1, OFF_STAT, {27'h0, 2'b11, lo, c});
      exec({OPC_LSUB, d, k});
      rd("sub acc", OFF_ACC, {25'h0, r});
      rd("sub flags", OFF_STAT, {28'h0, 2'b11, r == 8'h0, k[3:0] >= a[3:0], k >= a});
    end
    xfer(1'b1, OFF_STAT, 32'h0000000F);
    exec(14'h0062);
    rd("near halt", OFF_STAT, {25'h0, 8'h0F});
    exec(OPC_HALT);
    // Look between edges, once the halt's Q4 updates have settled.
    @(negedge pclk);
    check("sleep", {32'h0, sleep_mode}, 33'h1);
    check("watchdog", {25'h0, watchdog_counter}, 33'h0);
    @(posedge pclk);
    // The prescaler of four restarted at halt, so this read catches the first count.
    rd("watchdog count", OFF_WDOG, {25'h0, 8'h01});
    rd("halt flags", OFF_STAT, {25'h0, 8'h37});
    exec({OPC_RLC, 1'b0, 7'h05});
    rd("dropped", OFF_STAT, {25'h0, 8'hB7});
    xfer(1'b1, OFF_WAKE, 32'h1);
    rd("woken", OFF_STAT, {25'h0, 8'h97});
    check("pending", 33'(exp_q.size()), 33'h0);
    test_done();
  end
endmodule : tb
